//--- bench/flc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host processor on the shared register bus
module flc_host_model (
  input wire logic clk_sys_i, // System clock
  input wire logic [7:0] bus_i, // Bus value from the block
  input wire logic bus_oe_n_i, // Low while the block drives
  output logic cs_n_o, // Chip select
  output logic we_n_o, // Write strobe
  output logic re_n_o, // Read strobe
  output logic [1:0] sel_o, // Register select hi, lo
  output logic [7:0] data_o // Bus value from the host
);
  // Idle pins; a released bus shows the inverse of the last byte
  initial begin
    cs_n_o = 1'b1;
    we_n_o = 1'b1;
    re_n_o = 1'b1;
    sel_o = 2'h0;
    data_o = 8'hFF;
  end

  // Strobe held 4 clocks so the synchronised request lands, then idle 4
  task automatic wr(input logic [1:0] sel, input logic [7:0] val);
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    we_n_o <= 1'b0;
    sel_o <= sel;
    data_o <= val;
    repeat (4) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    we_n_o <= 1'b1;
    data_o <= ~val;
    repeat (4) @(posedge clk_sys_i);
  endtask

  // Data taken at the last edge before the strobe lets go
  task automatic rd(input logic [1:0] sel, output logic [7:0] val);
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    re_n_o <= 1'b0;
    sel_o <= sel;
    repeat (4) @(posedge clk_sys_i);
    val = bus_oe_n_i ? 8'hXX : bus_i;
    cs_n_o <= 1'b1;
    re_n_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top import flc_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cs_n, we_n, re_n;
  logic [1:0] sel;
  logic [7:0] din, dout, wr_byte, rd_byte = 8'h00, v;
  logic oe_n, drq_oe_n, irq_oe_n, step, dir, early, late, head_load_out, drq_lvl, irq_lvl;
  logic head_engaged_in = 1'b0, trk0 = 1'b1, rd_vld = 1'b0, take = 1'b0, done = 1'b0;
  logic pc_early = 1'b0, pc_late = 1'b0, exp_dir = 1'b0, rdy = 1'b1, step_q = 1'b0;
  int n_errors = 0, comparisons = 0, steps = 0, dir_bad = 0, cycles = 0, s0;
  // Select rows: register, value written, value read back
  localparam logic [17:0] ROWS [3] = '{{2'h1, 8'h02, 8'h02}, {2'h2, 8'hC3, 8'hC3},
    {2'h3, 8'h3C, 8'h3C}};

  // 50 MHz reference; stands in for the free-running timing clock
  always #10 clk_sys_i = ~clk_sys_i;

  flc_host_model i_host (.clk_sys_i(clk_sys_i), .bus_i(dout), .bus_oe_n_i(oe_n),
    .cs_n_o(cs_n), .we_n_o(we_n), .re_n_o(re_n), .sel_o(sel), .data_o(din));

  // No test pin on this block: the drive side is always in normal use
  flc_host_port #(.STEP_PULSE_CYCLES(3), .STEP_INTERVAL_CYCLES(20), .INVERT_BUS(1'b0)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .write_strobe_n_i(we_n),
    .read_strobe_n_i(re_n), .reg_select_hi_i(sel[1]), .reg_select_lo_i(sel[0]),
    .host_data_bus_i(din), .host_data_bus_o(dout), .host_data_bus_oe_n_o(oe_n),
    .byte_service_request_o(drq_lvl), .byte_service_request_oe_n_o(drq_oe_n),
    .operation_done_irq_o(irq_lvl), .operation_done_irq_oe_n_o(irq_oe_n), .step_o(step),
    .step_direction_o(dir), .early_o(early), .late_o(late), .head_load_out_o(head_load_out),
    .head_engaged_in_i(head_engaged_in), .drive_ready_i(rdy), .track_zero_i(trk0),
    .rd_byte_valid_i(rd_vld), .rd_byte_i(rd_byte), .wr_byte_take_i(take),
    .wr_byte_o(wr_byte), .sector_done_i(done), .wr_precomp_early_i(pc_early),
    .wr_precomp_late_i(pc_late));

  // Count step pulses on the falling edge, where step and direction are settled
  always @(negedge clk_sys_i) begin
    step_q <= step;
    if (step && !step_q) begin
      steps++;
      if (dir !== exp_dir) dir_bad++;
    end
  end

  // Hang guard, well above the longest expected run
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for a request pin to go active (released high)
  task automatic wait_req(input bit want_drq);
    int k;
    k = 0;
    while ((want_drq ? drq_oe_n : irq_oe_n) !== 1'b1 && k < 3000) begin
      @(posedge clk_sys_i);
      k++;
    end
    check({7'h00, want_drq ? drq_oe_n : irq_oe_n}, 8'h01);
  endtask

  // One-cycle datapath strobe: 0 byte valid, 1 byte taken, else sector done
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    case (k)
      0: rd_vld <= 1'b1;
      1: take <= 1'b1;
      default: done <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    rd_vld <= 1'b0;
    take <= 1'b0;
    done <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wait_req(1'b0);
    foreach (ROWS[i]) begin
      i_host.wr(ROWS[i][17:16], ROWS[i][15:8]);
      i_host.rd(ROWS[i][17:16], v);
      check(v, ROWS[i][7:0]);
    end
    // Seek from track 2 to 5: three steps inward
    trk0 <= 1'b0;
    exp_dir = 1'b1;
    s0 = steps;
    i_host.wr(SEL_DATA, 8'h05);
    i_host.wr(SEL_STAT_CMD, 8'h10);
    check({7'h00, irq_oe_n}, 8'h00);
    wait_req(1'b0);
    check(8'(steps - s0), 8'h03);
    i_host.rd(SEL_TRACK, v);
    check(v, 8'h05);
    i_host.rd(SEL_STAT_CMD, v);
    check({7'h00, irq_oe_n}, 8'h00);
    // Sector read: head load, byte ready, host takes it
    i_host.wr(SEL_STAT_CMD, 8'h80);
    check({7'h00, head_load_out}, 8'h01);
    head_engaged_in <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rd_byte <= 8'h96;
    pulse(0);
    check({7'h00, drq_oe_n}, 8'h01);
    i_host.rd(SEL_DATA, v);
    check(v, 8'h96);
    check({7'h00, drq_oe_n}, 8'h00);
    pulse(2);
    wait_req(1'b0);
    // Sector write: empty data register asks first, precomp flags follow
    i_host.wr(SEL_STAT_CMD, 8'hA0);
    wait_req(1'b1);
    @(posedge clk_sys_i);
    pc_early <= 1'b1;
    @(posedge clk_sys_i);
    pc_early <= 1'b0;
    pc_late <= 1'b1;
    @(negedge clk_sys_i);
    check({6'h00, early, late}, 8'h02);
    @(posedge clk_sys_i);
    pc_late <= 1'b0;
    @(negedge clk_sys_i);
    check({6'h00, early, late}, 8'h01);
    i_host.wr(SEL_DATA, 8'h55);
    check({7'h00, drq_oe_n}, 8'h00);
    pulse(1);
    check(wr_byte, 8'h55);
    check({7'h00, drq_oe_n}, 8'h01);
    pulse(2);
    wait_req(1'b0);
    // Second reset in mid-run: restore steps outward until track zero
    exp_dir = 1'b0;
    head_engaged_in <= 1'b0;
    rdy <= 1'b0;
    i_host.rd(SEL_STAT_CMD, v);
    check({7'h00, v[ST_NOT_READY]}, 8'h01);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    check({3'h0, drq_lvl, irq_lvl, drq_oe_n, irq_oe_n, step}, 8'h00);
    s0 = steps;
    rst_n_i <= 1'b1;
    rdy <= 1'b1;
    i_host.rd(SEL_SECTOR, v);
    check(v, SECTOR_RESET_VAL);
    i_host.rd(SEL_STAT_CMD, v);
    check({7'h00, v[ST_NOT_READY]}, 8'h00);
    while (steps - s0 < 3 && cycles < 19000) @(posedge clk_sys_i);
    trk0 <= 1'b1;
    wait_req(1'b0);
    check(8'(steps - s0), 8'h03);
    check(8'(dir_bad), 8'h00);
    i_host.rd(SEL_TRACK, v);
    check(v, 8'h00);
    finish_test();
  end
endmodule

//--- design/flc_host_port.sv
`timescale 1ns/1ps
// What this block does
// R1 - Reset held low 50 us minimum; command register becomes 03 hex.
// R2 - Not-ready status bit 7 cleared while reset is asserted.
// R3 - On reset release, sector register is 01 hex and restore runs unconditionally.
// R4 - Chip select plus write strobe low stores bus byte into selected register.
// R5 - Chip select plus read strobe low drives selected register onto bus.
// R6 - Select 00 status/command, 01 track, 10 sector, 11 data.
// R7 - Bus is input under write strobe, output under read; optional inversion.
// R8 - Outside party supplies steady timing clock.
// R9 - Data request when read byte assembled or write register empty.
// R10 - Reading or loading the data register drops data request.
// R11 - Interrupt on completion or abort; cleared by command write or status read.
// R12 - One step pulse for every head step.
// R13 - Direction high stepping in, low stepping out.
// R14 - Early output high during write pulses needing earlier placement.
// R15 - Late output high during write pulses needing later placement.
// R16 - Test input held high or open in normal use; this block has no test input.
// R17 - High head-engaged input means the head is loaded.
// R18 - Head-load output commands the drive to load the head.
// R19 - Requests are active high internally, open-drain at the pins.
module flc_host_port import flc_pkg::*; #(
  parameter int STEP_PULSE_CYCLES = STEP_PULSE_CYC,
  parameter int STEP_INTERVAL_CYCLES = STEP_INTERVAL_CYC,
  parameter bit INVERT_BUS = 1'b0
) (
  input wire logic clk_sys_i, // 50 MHz system clock
  input wire logic rst_n_i, // Master reset, active low
  input wire logic cs_n_i, // Chip select pin
  input wire logic write_strobe_n_i, // Write strobe pin
  input wire logic read_strobe_n_i, // Read strobe pin
  input wire logic reg_select_hi_i, // Register select high
  input wire logic reg_select_lo_i, // Register select low
  input wire logic [7:0] host_data_bus_i, // Data bus in
  output logic [7:0] host_data_bus_o, // Data bus out
  output logic host_data_bus_oe_n_o, // Low while driving bus
  output logic byte_service_request_o, // Open-drain level, always 0
  output logic byte_service_request_oe_n_o, // Low pulls pin low
  output logic operation_done_irq_o, // Open-drain level, always 0
  output logic operation_done_irq_oe_n_o, // Low pulls pin low
  output logic step_o, // Step pulse
  output logic step_direction_o, // Step direction
  output logic early_o, // Shift write pulse early
  output logic late_o, // Shift write pulse late
  output logic head_load_out_o, // Load head
  input wire logic head_engaged_in_i, // Head engaged pin
  input wire logic drive_ready_i, // Drive ready pin
  input wire logic track_zero_i, // Head at track zero pin
  input wire logic rd_byte_valid_i, // Datapath byte assembled
  input wire logic [7:0] rd_byte_i, // Datapath read byte
  input wire logic wr_byte_take_i, // Datapath takes write byte
  output logic [7:0] wr_byte_o, // Byte handed to datapath
  input wire logic sector_done_i, // Datapath transfer end
  input wire logic wr_precomp_early_i, // Encoder: pulse needs early
  input wire logic wr_precomp_late_i // Encoder: pulse needs late
);

  // Bus polarity conversion, same both ways
  function automatic logic [7:0] bus_conv(input logic [7:0] v);
    return INVERT_BUS ? ~v : v;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [15:0] sync1_reg, sync2_reg;
  logic wr_act_q_reg, rd_act_q_reg;

  // Data lines pass the same two stages as the strobes, so data must
  // be set up before the strobe falls
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= SYNC_RESET_VAL;
      sync2_reg <= SYNC_RESET_VAL;
    end else begin
      sync1_reg <= {cs_n_i, write_strobe_n_i, read_strobe_n_i, reg_select_hi_i,
                    reg_select_lo_i, head_engaged_in_i, drive_ready_i, track_zero_i,
                    host_data_bus_i};
      sync2_reg <= sync1_reg;
    end
  end

  wire [1:0] sel = sync2_reg[12:11];
  wire hlt_s = sync2_reg[10];
  wire ready_s = sync2_reg[9];
  wire tr0_s = sync2_reg[8];
  wire [7:0] bus_in = bus_conv(sync2_reg[7:0]);
  wire wr_act = ~sync2_reg[15] & ~sync2_reg[14]; // see R4
  wire rd_act = ~sync2_reg[15] & ~sync2_reg[13]; // see R5
  wire wr_start = wr_act & ~wr_act_q_reg;
  wire rd_start = rd_act & ~rd_act_q_reg;

  // ==========================================================
  // Register state
  flc_state_e state_reg, state_next;
  logic [7:0] cmd_reg, track_reg, sector_reg, data_reg, steps_reg;
  logic drq_reg, irq_reg, boot_reg, type1_reg, seek_err_reg, lost_reg;
  logic head_load_reg, not_ready_reg, single_done_reg;

  // Register select decode
  wire wr_cmd = wr_start & (sel == SEL_STAT_CMD); // see R6
  wire wr_trk = wr_start & (sel == SEL_TRACK);
  wire wr_sec = wr_start & (sel == SEL_SECTOR);
  wire wr_dat = wr_start & (sel == SEL_DATA);
  wire rd_stat = rd_start & (sel == SEL_STAT_CMD);
  wire rd_dat = rd_start & (sel == SEL_DATA);

  // Only an abort is taken while an operation runs
  wire is_force = bus_in[7:4] == OP_FORCE;
  wire cmd_ok = wr_cmd & ((state_reg == ST_IDLE) | is_force);
  wire new_op = cmd_ok & ~is_force;
  wire boot_go = boot_reg & (state_reg == ST_IDLE); // see R3

  // Active operation decode
  wire op_restore = cmd_reg[7:4] == OP_RESTORE;
  wire op_seek = cmd_reg[7:4] == OP_SEEK;
  wire op_single = ~cmd_reg[7] & cmd_reg[6];
  wire op_write = cmd_reg[7:5] == OP_WRITE;

  // ==========================================================
  // Stepping
  flc_step_if step_bus ();
  wire step_inward_w = op_restore ? 1'b0 : op_seek ? (data_reg > track_reg) : ~cmd_reg[5];
  wire seek_fin = op_restore ? (tr0_s | (steps_reg == RESTORE_MAX_STEPS)) :
                  op_seek ? (track_reg == data_reg) : single_done_reg;
  wire seek_end = (state_reg == ST_SEEK) & seek_fin & ~step_bus.step_busy;
  assign step_bus.step_req = (state_reg == ST_SEEK) & ~seek_fin & ~step_bus.step_busy;
  assign step_bus.step_inward = step_inward_w; // see R13
  wire trk_upd = step_bus.step_req & (op_seek | (op_single & cmd_reg[4]));

  flc_stepper #(
    .PULSE_CYC(STEP_PULSE_CYCLES),
    .INTERVAL_CYC(STEP_INTERVAL_CYCLES)
  ) u_stepper (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .step_bus(step_bus.drv),
    .step_o(step_o),
    .step_direction_o(step_direction_o)
  );

  // ==========================================================
  // Transfer events
  wire in_read = state_reg == ST_READ;
  wire in_write = state_reg == ST_WRITE;
  wire xfer_end = (in_read | in_write) & sector_done_i;
  wire abort = cmd_ok & is_force;
  wire op_done = seek_end | xfer_end | abort | (new_op & bus_in[7] &
                 (bus_in[7:6] != 2'b10)); // see R11
  wire drq_set = (in_read & rd_byte_valid_i) | (in_write & wr_byte_take_i) |
                 ((state_reg == ST_HEADWAIT) & hlt_s & op_write); // see R9
  wire drq_clr = (in_read & rd_dat) | (in_write & wr_dat) | op_done; // see R10
  wire irq_clr = cmd_ok | rd_stat; // see R11

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (new_op) begin
          state_next = ~bus_in[7] ? ST_SEEK :
                       (bus_in[7:6] == 2'b10) ? ST_HEADWAIT : ST_IDLE;
        end else if (boot_go) begin
          state_next = ST_SEEK;
        end
      end
      ST_SEEK: begin
        if (seek_end) begin
          state_next = ST_IDLE;
        end
      end
      ST_HEADWAIT: begin
        if (hlt_s) begin
          state_next = op_write ? ST_WRITE : ST_READ; // see R17
        end
      end
      ST_READ, ST_WRITE: begin
        if (sector_done_i) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    if (abort) begin
      state_next = ST_IDLE;
    end
  end

  // Status byte, layout depends on the last command class
  wire [7:0] status_w = {not_ready_reg, 1'b0, type1_reg & head_load_reg,
                         seek_err_reg, 1'b0, type1_reg ? tr0_s : lost_reg,
                         ~type1_reg & drq_reg, state_reg != ST_IDLE};
  wire [7:0] rd_mux = (sel == SEL_STAT_CMD) ? status_w : (sel == SEL_TRACK) ? track_reg :
                      (sel == SEL_SECTOR) ? sector_reg : data_reg; // see R6

  // ==========================================================
  // Control and request flags
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      boot_reg <= 1'b1;
      drq_reg <= 1'b0;
      irq_reg <= 1'b0;
      not_ready_reg <= 1'b0;
      wr_act_q_reg <= 1'b0;
      rd_act_q_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      boot_reg <= boot_reg & ~(boot_go & ~new_op);
      drq_reg <= drq_set | (drq_reg & ~drq_clr); // see R9
      irq_reg <= op_done | (irq_reg & ~irq_clr); // see R11
      not_ready_reg <= ~ready_s; // see R2
      wr_act_q_reg <= wr_act;
      rd_act_q_reg <= rd_act;
    end
  end

  // Command, track and sector registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_reg <= CMD_RESET_VAL; // see R1
      track_reg <= TRACK_RESET_VAL;
      sector_reg <= SECTOR_RESET_VAL; // see R3
    end else begin
      if (cmd_ok) begin
        cmd_reg <= bus_in; // see R4
      end
      if (seek_end & op_restore & tr0_s) begin
        track_reg <= TRACK_RESET_VAL;
      end else if (trk_upd) begin
        track_reg <= step_inward_w ? track_reg + 8'h01 : track_reg - 8'h01;
      end else if (wr_trk) begin
        track_reg <= bus_in;
      end
      if (wr_sec) begin
        sector_reg <= bus_in;
      end
    end
  end

  // Data register; the datapath wins a same-cycle collision
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_reg <= DATA_RESET_VAL;
      wr_byte_o <= DATA_RESET_VAL;
      lost_reg <= 1'b0;
    end else begin
      if (in_read & rd_byte_valid_i) begin
        data_reg <= rd_byte_i;
      end else if (wr_dat) begin
        data_reg <= bus_in;
      end
      if (in_write & wr_byte_take_i) begin
        wr_byte_o <= data_reg;
      end
      if (new_op) begin
        lost_reg <= 1'b0;
      end else if (drq_set & drq_reg & ~drq_clr) begin
        lost_reg <= 1'b1;
      end
    end
  end

  // Seek bookkeeping and head load
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      steps_reg <= 8'h00;
      single_done_reg <= 1'b0;
      seek_err_reg <= 1'b0;
      type1_reg <= 1'b1;
      head_load_reg <= 1'b0;
    end else begin
      if (new_op | boot_go) begin
        steps_reg <= 8'h00;
        single_done_reg <= 1'b0;
        seek_err_reg <= 1'b0;
        type1_reg <= new_op ? ~bus_in[7] : 1'b1;
      end else if (step_bus.step_req) begin
        steps_reg <= steps_reg + 8'h01;
        single_done_reg <= 1'b1;
      end else if (seek_end & op_restore) begin
        seek_err_reg <= ~tr0_s;
      end
      head_load_reg <= state_next inside {ST_HEADWAIT, ST_READ, ST_WRITE}; // see R18
    end
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_data_bus_o <= 8'h00;
      host_data_bus_oe_n_o <= 1'b1;
      early_o <= 1'b0;
      late_o <= 1'b0;
    end else begin
      host_data_bus_o <= rd_act ? bus_conv(rd_mux) : 8'h00; // see R5
      host_data_bus_oe_n_o <= ~rd_act; // see R7
      early_o <= in_write & wr_precomp_early_i; // see R14
      late_o <= in_write & wr_precomp_late_i; // see R15
    end
  end

  // Open drain: pin pulled low while the request is inactive
  assign byte_service_request_o = 1'b0;
  assign byte_service_request_oe_n_o = drq_reg; // see R19
  assign operation_done_irq_o = 1'b0;
  assign operation_done_irq_oe_n_o = irq_reg; // see R19
  assign head_load_out_o = head_load_reg;

  // ==========================================================
  // Checks
  sequence s_head_pending;
    (state_reg == ST_HEADWAIT) && !hlt_s && !abort;
  endsequence
  property p_head_wait;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_head_pending |=> (state_reg == ST_HEADWAIT) && head_load_out_o;
  endproperty
  a_head_wait: assert property (p_head_wait) else $error("moved without head"); // see R17

  property p_irq_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (irq_clr && !op_done) |=> operation_done_irq_oe_n_o == 1'b0;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared"); // see R11

  property p_irq_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    seek_end |=> operation_done_irq_oe_n_o && state_reg == ST_IDLE;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq missing at end"); // see R11

  property p_drq_rd_service;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (in_read && rd_dat && !rd_byte_valid_i) |=> !drq_reg;
  endproperty
  a_drq_rd_service: assert property (p_drq_rd_service) else $error("drq held"); // see R10

  property p_drq_wr_service;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (in_write && wr_dat && !wr_byte_take_i) |=> !drq_reg ##1 data_reg == $past(bus_in, 2);
  endproperty
  a_drq_wr_service: assert property (p_drq_wr_service) else $error("write not serviced"); // see R10

  property p_drq_byte;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (in_read && rd_byte_valid_i && !sector_done_i) |=> drq_reg && data_reg == $past(rd_byte_i);
  endproperty
  a_drq_byte: assert property (p_drq_byte) else $error("no drq for byte"); // see R9

  property p_bus_dir;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_act |=> !host_data_bus_oe_n_o && host_data_bus_o == bus_conv($past(rd_mux));
  endproperty
  a_bus_dir: assert property (p_bus_dir) else $error("read data not driven"); // see R5

  property p_bus_quiet;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !rd_act |=> host_data_bus_oe_n_o;
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("bus driven outside read"); // see R7

  property p_boot_restore;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (boot_go && !wr_cmd) |=> state_reg == ST_SEEK && op_restore && sector_reg == SECTOR_RESET_VAL;
  endproperty
  a_boot_restore: assert property (p_boot_restore) else $error("no restore after reset"); // see R3

  property p_step_dir;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    step_bus.step_req |=> step_o ##0 step_direction_o == $past(step_inward_w);
  endproperty
  a_step_dir: assert property (p_step_dir) else $error("step or direction wrong"); // see R13

endmodule

//--- design/flc_pkg.sv
package flc_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MR_MIN_US = 50;
  localparam int MR_MIN_CYC = (MR_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_PULSE_US = 2;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_INTERVAL_US = 6000;
  localparam int STEP_INTERVAL_CYC =
    (STEP_INTERVAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CMD_RESET_VAL = 8'h03;
  localparam logic [7:0] SECTOR_RESET_VAL = 8'h01;
  localparam logic [7:0] TRACK_RESET_VAL = 8'h00;
  localparam logic [7:0] DATA_RESET_VAL = 8'h00;
  localparam logic [7:0] RESTORE_MAX_STEPS = 8'hFF;
  // Pin synchroniser idle: chip select, both strobes and drive ready high,
  // so status shows no false not-ready before the real pin arrives
  localparam logic [15:0] SYNC_RESET_VAL = 16'hE200;

  // ==========================================================
  // Register select codes
  localparam logic [1:0] SEL_STAT_CMD = 2'h0;
  localparam logic [1:0] SEL_TRACK = 2'h1;
  localparam logic [1:0] SEL_SECTOR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;

  // ==========================================================
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DRQ = 1;
  localparam int ST_LOST_TRK0 = 2;
  localparam int ST_SEEK_ERR = 4;
  localparam int ST_HEAD = 5;
  localparam int ST_NOT_READY = 7;

  // ==========================================================
  // Command opcodes (upper bits)
  localparam logic [3:0] OP_RESTORE = 4'h0;
  localparam logic [3:0] OP_SEEK = 4'h1;
  localparam logic [3:0] OP_FORCE = 4'hD;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_WRITE = 3'h5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_HEADWAIT = 3'b010,
    ST_READ = 3'b011,
    ST_WRITE = 3'b100
  } flc_state_e;

endpackage

//--- design/flc_step_if.sv
`timescale 1ns/1ps
// ==========================================================
// Step request path between controller and step generator
interface flc_step_if;
  logic step_req;
  logic step_inward;
  logic step_busy;
  modport ctrl (output step_req, output step_inward, input step_busy);
  modport drv (input step_req, input step_inward, output step_busy);
endinterface

//--- design/flc_stepper.sv
`timescale 1ns/1ps
module flc_stepper import flc_pkg::*; #(
  parameter int PULSE_CYC = STEP_PULSE_CYC,
  parameter int INTERVAL_CYC = STEP_INTERVAL_CYC
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  flc_step_if.drv step_bus, // Requests from controller
  output logic step_o, // Step pulse to drive
  output logic step_direction_o // High = inward
);

  localparam int CW = $clog2(INTERVAL_CYC + 1);
  logic [CW-1:0] cnt_reg;
  logic accept;

  // ==========================================================
  // Interval counter; busy until the head has settled
  assign step_bus.step_busy = (cnt_reg != '0);
  assign accept = step_bus.step_req & ~step_bus.step_busy;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (accept) begin
      cnt_reg <= CW'(INTERVAL_CYC - 1);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // One pulse per accepted step, direction frozen under it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_o <= 1'b0;
      step_direction_o <= 1'b0;
    end else begin
      step_o <= accept | (step_o & (cnt_reg != CW'(INTERVAL_CYC - PULSE_CYC))); // see R12
      if (accept) begin
        step_direction_o <= step_bus.step_inward; // see R13
      end
    end
  end

  // ==========================================================
  // Checks
  property p_step_cause;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(step_o) |-> $past(accept) && cnt_reg == CW'(INTERVAL_CYC - 1);
  endproperty
  a_step_cause: assert property (p_step_cause) else $error("step without request"); // see R12

  property p_step_width;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(step_o) |-> $past(cnt_reg) == CW'(INTERVAL_CYC - PULSE_CYC);
  endproperty
  a_step_width: assert property (p_step_width) else $error("step width wrong"); // see R12

  property p_dir_stable;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (step_o && $past(step_o)) |-> $stable(step_direction_o);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("direction moved in pulse"); // see R13

endmodule
